// >>> hw/nand_pkg.sv
// shared constants, types and register map of the flash access port
// assumes one 200 MHz clock domain and an AHB-Lite register bus
package nand_pkg;

	// ==========================================================
	// address map
	localparam int unsigned ADDR_W    = 13;
	localparam int unsigned BUF_BIT   = 12;
	localparam int unsigned BUF_WORDS = 1024;
	localparam logic [11:0] OFS_CONFIG     = 12'h000;
	localparam logic [11:0] OFS_CONTROL    = 12'h004;
	localparam logic [11:0] OFS_COMMAND    = 12'h008;
	localparam logic [11:0] OFS_ADDRESS    = 12'h00c;
	localparam logic [11:0] OFS_DATA       = 12'h010;
	localparam logic [11:0] OFS_MECC_LOW   = 12'h014;
	localparam logic [11:0] OFS_MECC_HIGH  = 12'h018;
	localparam logic [11:0] OFS_SECC       = 12'h01c;
	localparam logic [11:0] OFS_MRES_LANE0 = 12'h020;
	localparam logic [11:0] OFS_MRES_LANE1 = 12'h024;
	localparam logic [11:0] OFS_SRES       = 12'h028;
	localparam logic [11:0] OFS_STATUS     = 12'h02c;

	// ==========================================================
	// field positions and reset values
	localparam int unsigned CFG_SETUP_LSB  = 12;
	localparam int unsigned CFG_WIDTH_LSB  = 8;
	localparam int unsigned CFG_HOLD_LSB   = 4;
	localparam int unsigned CFG_LANE_BIT   = 0;
	localparam logic [1:0]  CFG_SETUP_RST  = 2'h1;
	localparam logic [2:0]  CFG_WIDTH_RST  = 3'h0;
	localparam logic [2:0]  CFG_HOLD_RST   = 3'h0;
	localparam int unsigned CTL_DESEL_BIT  = 1;
	localparam int unsigned CTL_BIG_BIT    = 2;
	localparam int unsigned CTL_INIT_BIT   = 4;
	localparam int unsigned CTL_MLOCK_BIT  = 5;
	localparam int unsigned CTL_SLOCK_BIT  = 6;
	localparam logic        CTL_DESEL_RST  = 1'b1;
	localparam int unsigned STAT_READY_BIT = 0;

	// ==========================================================
	// timing and bus encodings
	localparam logic [3:0] READ_CAPTURE_CNT = 4'h2;
	localparam logic [1:0] STRAP_SETTLE     = 2'h2;
	localparam logic [2:0] HSIZE_BYTE       = 3'h0;
	localparam logic [2:0] HSIZE_HALF       = 3'h1;
	localparam logic [2:0] HSIZE_WORD       = 3'h2;
	localparam logic [2:0] ECC_XFERS        = 3'h2;
	localparam logic [10:0] MAIN_LINE_MASK  = 11'h7ff;
	localparam logic [10:0] SPARE_LINE_MASK = 11'h00f;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_ACCESS = 6'b000010,
		ST_SETUP  = 6'b000100,
		ST_STROBE = 6'b001000,
		ST_HOLD   = 6'b010000,
		ST_RESP   = 6'b100000
	} state_t;

	typedef enum logic [2:0] {
		OP_REG  = 3'h0,
		OP_CMD  = 3'h1,
		OP_ADDR = 3'h2,
		OP_DATA = 3'h3,
		OP_ECC  = 3'h4,
		OP_BUF  = 3'h5
	} op_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [2:0]        size;
	} req_t;

	// parity accumulator: line pairs, column pairs {4,4',2,2',1,1'}
	typedef struct packed {
		logic [10:0] line_t;
		logic [10:0] line_c;
		logic [5:0]  col;
		logic [10:0] count;
	} gen_t;

endpackage

// >>> hw/nand_sw_port.sv
// software driven flash access port with parity generators and boot buffer
// assumes an AHB-Lite master on CORE_CLK_IN and asynchronous flash pins
//
// Notes on behaviour
// - only register-driven access; no self-running page sequencing.
// - each command register write makes one command cycle with that value.
// - each address register write makes one address cycle with that value.
// - data register write becomes flash write cycles of its bytes.
// - data register read becomes flash read cycles returning fetched bytes.
// - reading ECC check registers also performs flash read cycles.
// - 16-bit bus: word two transfers, endian orders halves; half one.
// - 8-bit bus: word four, half two, byte one transfer, endian ordered.
// - four generators, main per lane up to 2048 bytes, spare up to 16.
// - main code is 22 line bits plus 6 column bits.
// - spare code is 8 line bits plus 6 column bits.
// - main parity bytes packed as true/complement pairs in set order.
// - spare parity bytes packed as pairs, byte two low bits unused.
// - separate main and spare locks; generators update only unlocked.
// - writing init bit clears parity; software unlocks main first.
// - unlocked main generators fold every transferred data byte.
// - main result holds once software sets main lock.
// - spare lock cleared lets spare generators accumulate.
// - spare result frozen once spare lock is set.
// - main check registers: bytes one-two low, three-four high, lane order.
// - spare check register holds first and second spare bytes per lane.
// - 4 KB buffer usable as general memory.
// - latch strobes held for setup setting cycles, 0 to 3.
// - strobe low width is one plus width setting cycles.
// - hold after strobe rise is one plus hold setting cycles, but at least three cycles on reads.
// - lane width bit selects 8-bit or 16-bit bus, software writable.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

module nand_sw_port (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	input  wire logic        LANE_WIDTH_STRAP_IN,
	input  wire logic        FLASH_READY_BUSY_N_IN,
	input  wire logic [15:0] FLASH_IO_IN,
	output logic      [15:0] FLASH_IO_OUT,
	output logic             FLASH_IO_OE_OUT,
	output logic             FLASH_CLE_OUT,
	output logic             FLASH_ALE_OUT,
	output logic             FLASH_WE_N_OUT,
	output logic             FLASH_RE_N_OUT,
	output logic             FLASH_CE_N_OUT
);

	// ==========================================================
	// functions
	function automatic nand_pkg::op_t decode_op(input logic [nand_pkg::ADDR_W-1:0] a,
			input logic wr);
		decode_op = nand_pkg::OP_REG;
		if (a[nand_pkg::BUF_BIT])
			decode_op = nand_pkg::OP_BUF;
		else if (a[11:0] == nand_pkg::OFS_COMMAND && wr)
			decode_op = nand_pkg::OP_CMD;
		else if (a[11:0] == nand_pkg::OFS_ADDRESS && wr)
			decode_op = nand_pkg::OP_ADDR;
		else if (a[11:0] == nand_pkg::OFS_DATA)
			decode_op = nand_pkg::OP_DATA;
		else if (a[11:0] == nand_pkg::OFS_MECC_LOW ||
				a[11:0] == nand_pkg::OFS_MECC_HIGH ||
				a[11:0] == nand_pkg::OFS_SECC)
			decode_op = nand_pkg::OP_ECC;
	endfunction

	function automatic logic [2:0] data_xfers(input logic [2:0] size,
			input logic wide);
		if (wide)
			data_xfers = (size == nand_pkg::HSIZE_WORD) ? 3'h2 : 3'h1;
		else if (size == nand_pkg::HSIZE_WORD)
			data_xfers = 3'h4;
		else if (size == nand_pkg::HSIZE_HALF)
			data_xfers = 3'h2;
		else
			data_xfers = 3'h1;
	endfunction

	// one byte into a generator; mask limits line pairs to the area size
	function automatic nand_pkg::gen_t gen_step(input nand_pkg::gen_t g,
			input logic [7:0] d, input logic [10:0] mask);
		logic bp;
		gen_step = g;
		bp = ^d;
		gen_step.col = g.col ^ {^d[7:4], ^d[3:0], ^{d[7:6], d[3:2]},
			^{d[5:4], d[1:0]}, ^{d[7], d[5], d[3], d[1]},
			^{d[6], d[4], d[2], d[0]}};
		gen_step.line_t = g.line_t ^ (g.count & mask & {11{bp}});
		gen_step.line_c = g.line_c ^ (~g.count & mask & {11{bp}});
		gen_step.count = g.count + 11'h001;
	endfunction

	function automatic logic [1:0] pr(input nand_pkg::gen_t g, input int i);
		pr = {g.line_t[i], g.line_c[i]};
	endfunction

	function automatic logic [31:0] main_pack(input nand_pkg::gen_t g);
		main_pack = {pr(g, 10), pr(g, 9), 4'h0,
			g.col, pr(g, 8),
			pr(g, 7), pr(g, 6), pr(g, 5), pr(g, 4),
			pr(g, 3), pr(g, 2), pr(g, 1), pr(g, 0)};
	endfunction

	function automatic logic [15:0] spare_pack(input nand_pkg::gen_t g);
		spare_pack = {g.col[1:0], pr(g, 3), pr(g, 2), 2'h0,
			pr(g, 1), pr(g, 0), g.col[5:2]};
	endfunction

	// ==========================================================
	// declarations
	nand_pkg::state_t  st_ff;
	nand_pkg::req_t    req_ff;
	nand_pkg::op_t     op_ff;
	nand_pkg::gen_t    main_ff  [2];
	nand_pkg::gen_t    spare_ff [2];
	logic [3:0]        cnt_ff;
	logic [2:0]        xfer_ff;
	logic [2:0]        nx_ff;
	logic [31:0]       wdata_ff;
	logic [31:0]       hrdata_ff;
	logic [1:0]        rb_sync_ff;
	logic [1:0]        strap_sync_ff;
	logic [15:0]       io_s1_ff;
	logic [15:0]       io_s2_ff;
	logic [1:0]        strap_wait_ff;
	logic [1:0]        setup_ff;
	logic [2:0]        width_ff;
	logic [2:0]        hold_ff;
	logic              wide_ff;
	logic              desel_ff;
	logic              big_ff;
	logic              mlock_ff;
	logic              slock_ff;
	logic              cle_ff;
	logic              ale_ff;
	logic              we_n_ff;
	logic              re_n_ff;
	logic              oe_ff;
	logic [15:0]       io_out_ff;
	logic [31:0]       buf_mem [nand_pkg::BUF_WORDS];
	logic              resp_free;
	logic              accept;
	logic              in_access;
	logic              reg_wr;
	logic              init_pulse;
	logic              reading;
	logic              flash_latch;
	logic [3:0]        hold_last;
	logic [2:0]        slot;
	logic [4:0]        pos;
	logic [15:0]       wbits;
	logic [15:0]       out_word;
	logic [15:0]       cap_word;
	logic              ecc_fire;
	logic [15:0]       ecc_word;
	logic [31:0]       reg_rd_val;
	logic [11:0]       ofs;
	logic [3:0]        byte_en;

	// ==========================================================
	// synchronisers and strap capture
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rb_sync_ff    <= 2'h0;
			strap_sync_ff <= 2'h0;
			io_s1_ff      <= 16'h0000;
			io_s2_ff      <= 16'h0000;
		end else begin
			rb_sync_ff    <= {rb_sync_ff[0], FLASH_READY_BUSY_N_IN};
			strap_sync_ff <= {strap_sync_ff[0], LANE_WIDTH_STRAP_IN};
			io_s1_ff      <= FLASH_IO_IN;
			io_s2_ff      <= io_s1_ff;
		end
	end

	// ==========================================================
	// bus side decode
	assign resp_free  = (st_ff == nand_pkg::ST_IDLE) || (st_ff == nand_pkg::ST_RESP);
	assign accept     = HSEL_IN && HTRANS_IN[1] && HREADY_IN && resp_free;
	assign in_access  = (st_ff == nand_pkg::ST_ACCESS);
	assign ofs        = req_ff.addr[11:0];
	assign reg_wr     = in_access && req_ff.write && op_ff == nand_pkg::OP_REG;
	assign init_pulse = reg_wr && ofs == nand_pkg::OFS_CONTROL &&
		HWDATA_IN[nand_pkg::CTL_INIT_BIT];
	assign reading    = !req_ff.write;
	assign flash_latch = (op_ff == nand_pkg::OP_CMD) || (op_ff == nand_pkg::OP_ADDR);
	assign HREADYOUT_OUT = resp_free;
	assign HRESP_OUT     = 1'b0;
	assign HRDATA_OUT    = hrdata_ff;

	// ==========================================================
	// configuration and control registers
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			setup_ff      <= nand_pkg::CFG_SETUP_RST;
			width_ff      <= nand_pkg::CFG_WIDTH_RST;
			hold_ff       <= nand_pkg::CFG_HOLD_RST;
			wide_ff       <= 1'b0;
			strap_wait_ff <= 2'h0;
		end else if (strap_wait_ff != nand_pkg::STRAP_SETTLE) begin
			// strap sampled only in the two settle cycles, before the synchroniser has flushed
			strap_wait_ff <= strap_wait_ff + 2'h1;
			wide_ff       <= strap_sync_ff[1];
		end else if (reg_wr && ofs == nand_pkg::OFS_CONFIG) begin
			setup_ff <= HWDATA_IN[nand_pkg::CFG_SETUP_LSB +: 2];
			width_ff <= HWDATA_IN[nand_pkg::CFG_WIDTH_LSB +: 3];
			hold_ff  <= HWDATA_IN[nand_pkg::CFG_HOLD_LSB +: 3];
			wide_ff  <= HWDATA_IN[nand_pkg::CFG_LANE_BIT];
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			desel_ff <= nand_pkg::CTL_DESEL_RST;
			big_ff   <= 1'b0;
			mlock_ff <= 1'b0;
			slock_ff <= 1'b0;
		end else if (reg_wr && ofs == nand_pkg::OFS_CONTROL) begin
			desel_ff <= HWDATA_IN[nand_pkg::CTL_DESEL_BIT];
			big_ff   <= HWDATA_IN[nand_pkg::CTL_BIG_BIT];
			mlock_ff <= HWDATA_IN[nand_pkg::CTL_MLOCK_BIT];
			slock_ff <= HWDATA_IN[nand_pkg::CTL_SLOCK_BIT];
		end
	end

	always_comb begin
		reg_rd_val = 32'h0000_0000;
		case (ofs)
		nand_pkg::OFS_CONFIG: begin
			reg_rd_val[nand_pkg::CFG_SETUP_LSB +: 2] = setup_ff;
			reg_rd_val[nand_pkg::CFG_WIDTH_LSB +: 3] = width_ff;
			reg_rd_val[nand_pkg::CFG_HOLD_LSB +: 3]  = hold_ff;
			reg_rd_val[nand_pkg::CFG_LANE_BIT]       = wide_ff;
		end
		nand_pkg::OFS_CONTROL: begin
			reg_rd_val[nand_pkg::CTL_DESEL_BIT] = desel_ff;
			reg_rd_val[nand_pkg::CTL_BIG_BIT]   = big_ff;
			reg_rd_val[nand_pkg::CTL_MLOCK_BIT] = mlock_ff;
			reg_rd_val[nand_pkg::CTL_SLOCK_BIT] = slock_ff;
		end
		nand_pkg::OFS_MRES_LANE0: reg_rd_val = main_pack(main_ff[0]);
		nand_pkg::OFS_MRES_LANE1: reg_rd_val = main_pack(main_ff[1]);
		nand_pkg::OFS_SRES:
			reg_rd_val = {spare_pack(spare_ff[1]), spare_pack(spare_ff[0])};
		// ready/busy visible so software can poll it between cycles
		nand_pkg::OFS_STATUS: reg_rd_val[nand_pkg::STAT_READY_BIT] = rb_sync_ff[1];
		default: reg_rd_val = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// transfer placement
	assign slot = (op_ff == nand_pkg::OP_DATA && big_ff) ?
		3'(nx_ff - 3'h1 - xfer_ff) : xfer_ff;
	// check registers always step by 16 bits per transfer
	assign pos = (op_ff == nand_pkg::OP_ECC || wide_ff) ?
		{slot[0], 4'h0} : {slot[1:0], 3'h0};
	assign wbits    = 16'(wdata_ff >> pos);
	assign out_word = wide_ff ? wbits : {8'h00, wbits[7:0]};
	assign cap_word = wide_ff ? io_s2_ff : {8'h00, io_s2_ff[7:0]};
	assign hold_last = (reading && {1'b0, hold_ff} < nand_pkg::READ_CAPTURE_CNT) ?
		nand_pkg::READ_CAPTURE_CNT : {1'b0, hold_ff};

	// ==========================================================
	// access sequencer: one bus access, one run of flash cycles, no more
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_ff    <= nand_pkg::ST_IDLE;
			req_ff   <= '0;
			op_ff    <= nand_pkg::OP_REG;
			cnt_ff   <= 4'h0;
			xfer_ff  <= 3'h0;
			nx_ff    <= 3'h1;
			wdata_ff <= 32'h0000_0000;
		end else begin
			case (st_ff)
			nand_pkg::ST_IDLE, nand_pkg::ST_RESP: begin
				if (accept) begin
					st_ff  <= nand_pkg::ST_ACCESS;
					req_ff <= '{addr: HADDR_IN[nand_pkg::ADDR_W-1:0],
						write: HWRITE_IN, size: HSIZE_IN};
					op_ff  <= decode_op(HADDR_IN[nand_pkg::ADDR_W-1:0], HWRITE_IN);
				end else begin
					st_ff <= nand_pkg::ST_IDLE;
				end
			end
			nand_pkg::ST_ACCESS: begin
				wdata_ff <= HWDATA_IN;
				cnt_ff   <= 4'h0;
				xfer_ff  <= 3'h0;
				case (op_ff)
				nand_pkg::OP_CMD, nand_pkg::OP_ADDR: begin
					nx_ff <= 3'h1;
					st_ff <= (setup_ff != 2'h0) ? nand_pkg::ST_SETUP :
						nand_pkg::ST_STROBE;
				end
				nand_pkg::OP_DATA: begin
					nx_ff <= data_xfers(req_ff.size, wide_ff);
					st_ff <= nand_pkg::ST_STROBE;
				end
				nand_pkg::OP_ECC: begin
					nx_ff <= nand_pkg::ECC_XFERS;
					// writes to check registers carry no flash cycle
					st_ff <= req_ff.write ? nand_pkg::ST_RESP :
						nand_pkg::ST_STROBE;
				end
				default: st_ff <= nand_pkg::ST_RESP;
				endcase
			end
			nand_pkg::ST_SETUP: begin
				if (cnt_ff == {2'h0, setup_ff - 2'h1}) begin
					cnt_ff <= 4'h0;
					st_ff  <= nand_pkg::ST_STROBE;
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
			nand_pkg::ST_STROBE: begin
				if (cnt_ff == {1'b0, width_ff}) begin
					cnt_ff <= 4'h0;
					st_ff  <= nand_pkg::ST_HOLD;
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
			nand_pkg::ST_HOLD: begin
				if (cnt_ff == hold_last) begin
					cnt_ff <= 4'h0;
					if (xfer_ff + 3'h1 < nx_ff) begin
						xfer_ff <= xfer_ff + 3'h1;
						st_ff   <= nand_pkg::ST_STROBE;
					end else begin
						st_ff <= nand_pkg::ST_RESP;
					end
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
			default: st_ff <= nand_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// read data
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (in_access && reading) begin
			case (op_ff)
			nand_pkg::OP_REG: hrdata_ff <= reg_rd_val;
			nand_pkg::OP_BUF: hrdata_ff <= buf_mem[req_ff.addr[11:2]];
			default: hrdata_ff <= 32'h0000_0000; // invalid lanes read zero
			endcase
		end else if (st_ff == nand_pkg::ST_HOLD && reading &&
				cnt_ff == nand_pkg::READ_CAPTURE_CNT) begin
			hrdata_ff <= hrdata_ff | ({16'h0000, cap_word} << pos);
		end
	end

	// ==========================================================
	// general purpose buffer
	always_comb begin
		byte_en = 4'hf;
		if (req_ff.size == nand_pkg::HSIZE_BYTE)
			byte_en = 4'h1 << req_ff.addr[1:0];
		else if (req_ff.size == nand_pkg::HSIZE_HALF)
			byte_en = req_ff.addr[1] ? 4'hc : 4'h3;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (in_access && req_ff.write && op_ff == nand_pkg::OP_BUF) begin
			for (int b = 0; b < 4; b++) begin
				if (byte_en[b])
					buf_mem[req_ff.addr[11:2]][8*b +: 8] <= HWDATA_IN[8*b +: 8];
			end
		end
	end

	// ==========================================================
	// flash pins, registered one cycle behind the sequencer
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cle_ff    <= 1'b0;
			ale_ff    <= 1'b0;
			we_n_ff   <= 1'b1;
			re_n_ff   <= 1'b1;
			oe_ff     <= 1'b0;
			io_out_ff <= 16'h0000;
		end else begin
			cle_ff  <= op_ff == nand_pkg::OP_CMD && (st_ff == nand_pkg::ST_SETUP ||
				st_ff == nand_pkg::ST_STROBE || st_ff == nand_pkg::ST_HOLD);
			ale_ff  <= op_ff == nand_pkg::OP_ADDR && (st_ff == nand_pkg::ST_SETUP ||
				st_ff == nand_pkg::ST_STROBE || st_ff == nand_pkg::ST_HOLD);
			we_n_ff <= !(st_ff == nand_pkg::ST_STROBE && req_ff.write);
			re_n_ff <= !(st_ff == nand_pkg::ST_STROBE && reading);
			oe_ff   <= req_ff.write && (st_ff == nand_pkg::ST_SETUP ||
				st_ff == nand_pkg::ST_STROBE || st_ff == nand_pkg::ST_HOLD);
			if (st_ff == nand_pkg::ST_STROBE || st_ff == nand_pkg::ST_SETUP)
				io_out_ff <= out_word;
		end
	end

	assign FLASH_CLE_OUT   = cle_ff;
	assign FLASH_ALE_OUT   = ale_ff;
	assign FLASH_WE_N_OUT  = we_n_ff;
	assign FLASH_RE_N_OUT  = re_n_ff;
	assign FLASH_IO_OE_OUT = oe_ff;
	assign FLASH_IO_OUT    = io_out_ff;
	assign FLASH_CE_N_OUT  = desel_ff;

	// ==========================================================
	// parity generators, one main and one spare per byte lane
	assign ecc_fire = (op_ff == nand_pkg::OP_DATA || op_ff == nand_pkg::OP_ECC) &&
		((st_ff == nand_pkg::ST_STROBE && req_ff.write && cnt_ff == {1'b0, width_ff}) ||
		(st_ff == nand_pkg::ST_HOLD && reading &&
		cnt_ff == nand_pkg::READ_CAPTURE_CNT));
	assign ecc_word = req_ff.write ? out_word : cap_word;

	for (genvar g = 0; g < 2; g++) begin : gen_lane
		always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
			if (RST_IN) begin
				main_ff[g]  <= '0;
				spare_ff[g] <= '0;
			end else if (init_pulse) begin
				main_ff[g]  <= '0;
				spare_ff[g] <= '0;
			end else if (ecc_fire && (g == 0 || wide_ff)) begin
				if (!mlock_ff)
					main_ff[g] <= gen_step(main_ff[g], ecc_word[8*g +: 8],
						nand_pkg::MAIN_LINE_MASK);
				if (!slock_ff)
					spare_ff[g] <= gen_step(spare_ff[g], ecc_word[8*g +: 8],
						nand_pkg::SPARE_LINE_MASK);
			end
		end
	end

endmodule // nand_sw_port

// >>> bench/nand_sw_port_checker.sv
// pin-level assertions for the flash access port
// assumes reset strobe timing (setup 1, width 0, hold 0) stays in force
`timescale 1ns/1ps

module nand_sw_port_checker (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HREADY_IN,
	input  wire logic        HREADYOUT_OUT,
	input  wire logic [15:0] FLASH_IO_OUT,
	input  wire logic        FLASH_IO_OE_OUT,
	input  wire logic        FLASH_CLE_OUT,
	input  wire logic        FLASH_ALE_OUT,
	input  wire logic        FLASH_WE_N_OUT,
	input  wire logic        FLASH_RE_N_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	// ==========================================================
	// flash strobe shapes
	sequence s_we_pulse;
		$fell(FLASH_WE_N_OUT) ##1 $rose(FLASH_WE_N_OUT);
	endsequence
	property p_cmd_cycle;
		$rose(FLASH_CLE_OUT) |=> s_we_pulse ##1 $fell(FLASH_CLE_OUT);
	endproperty
	a_cmd_cycle: assert property (p_cmd_cycle)
		else $error("command cycle shape wrong");
	property p_addr_cycle;
		$rose(FLASH_ALE_OUT) |=> s_we_pulse ##1 $fell(FLASH_ALE_OUT);
	endproperty
	a_addr_cycle: assert property (p_addr_cycle)
		else $error("address cycle shape wrong");
	property p_wdata;
		$fell(FLASH_WE_N_OUT) && !FLASH_CLE_OUT && !FLASH_ALE_OUT
			|-> FLASH_IO_OE_OUT ##1 $rose(FLASH_WE_N_OUT) && $stable(FLASH_IO_OUT);
	endproperty
	a_wdata: assert property (p_wdata)
		else $error("data write strobe wrong");
	property p_rdata;
		$fell(FLASH_RE_N_OUT) |-> !FLASH_IO_OE_OUT ##1 $rose(FLASH_RE_N_OUT);
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read strobe wrong");
	property p_latch_excl;
		!(FLASH_CLE_OUT && FLASH_ALE_OUT);
	endproperty
	a_latch_excl: assert property (p_latch_excl)
		else $error("both latch strobes high");
	property p_strobe_excl;
		!(!FLASH_WE_N_OUT && !FLASH_RE_N_OUT);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl)
		else $error("write and read strobes both low");
	property p_stall;
		!FLASH_WE_N_OUT || !FLASH_RE_N_OUT |-> !HREADYOUT_OUT;
	endproperty
	a_stall: assert property (p_stall)
		else $error("bus released during flash cycle");
	// every access waits at least one cycle, but never forever
	property p_access;
		HSEL_IN && HTRANS_IN[1] && HREADY_IN && HREADYOUT_OUT
			|=> !HREADYOUT_OUT ##[1:60] HREADYOUT_OUT;
	endproperty
	a_access: assert property (p_access)
		else $error("access wait wrong");
endmodule // nand_sw_port_checker

bind nand_sw_port nand_sw_port_checker i_checker (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .HSEL_IN(HSEL_IN),
	.HTRANS_IN(HTRANS_IN), .HREADY_IN(HREADY_IN),
	.HREADYOUT_OUT(HREADYOUT_OUT), .FLASH_IO_OUT(FLASH_IO_OUT),
	.FLASH_IO_OE_OUT(FLASH_IO_OE_OUT), .FLASH_CLE_OUT(FLASH_CLE_OUT),
	.FLASH_ALE_OUT(FLASH_ALE_OUT), .FLASH_WE_N_OUT(FLASH_WE_N_OUT),
	.FLASH_RE_N_OUT(FLASH_RE_N_OUT));

// >>> bench/nand_flash_model.sv
// behavioural flash device on the far side of the port
// assumes the bench resolves the shared data lines from the port's output enable
`timescale 1ns/1ps

module nand_flash_model (
	input  wire logic        cle_in,
	input  wire logic        ale_in,
	input  wire logic        we_n_in,
	input  wire logic        re_n_in,
	input  wire logic [15:0] io_in,
	output logic      [15:0] io_out,
	output logic             ready_busy_n_out
);
	logic [7:0]  last_cmd;
	logic [7:0]  last_addr;
	logic [15:0] wr_log[$];
	int          rd_cnt = 0;
	initial begin
		io_out = 16'h0f0f;
		ready_busy_n_out = 1'b1;
	end
	// ==========================================================
	// latching on the rising write strobe
	always @(posedge we_n_in) begin
		if (cle_in) begin
			last_cmd = io_in[7:0];
			// program confirm keeps the part busy for a while
			if (io_in[7:0] == 8'h10) begin
				ready_busy_n_out = 1'b0;
				ready_busy_n_out <= #300 1'b1;
			end
		end else if (ale_in) begin
			last_addr = io_in[7:0];
		end else begin
			wr_log.push_back(io_in);
		end
	end
	always @(negedge re_n_in) begin
		io_out = 16'h3c5a + 16'(rd_cnt) * 16'h1111;
		rd_cnt++;
	end
	// data hold runs out shortly after the strobe rises
	always @(posedge re_n_in) begin
		#6 io_out = ~io_out;
	end
endmodule // nand_flash_model

// >>> bench/nand_sw_port_test.sv
// self-checking bench for the flash access port
// assumes the design, package, checker and flash model are compiled first
`timescale 1ns/1ps

module nand_sw_port_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rdata;
	logic        hready, oe, cle, ale, we_n, re_n, rb_n, ce_n, hresp;
	logic [15:0] io_out, io_mod;
	wire  [15:0] io_wire = oe ? io_out : io_mod;
	int          mismatches = 0;
	int          samples_checked = 0;

	always #2.5 clk = ~clk;

	nand_sw_port i_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
		.HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.LANE_WIDTH_STRAP_IN(1'b0), .FLASH_READY_BUSY_N_IN(rb_n),
		.FLASH_IO_IN(io_wire), .FLASH_IO_OUT(io_out), .FLASH_IO_OE_OUT(oe),
		.FLASH_CLE_OUT(cle), .FLASH_ALE_OUT(ale), .FLASH_WE_N_OUT(we_n),
		.FLASH_RE_N_OUT(re_n), .FLASH_CE_N_OUT(ce_n));
	nand_flash_model i_flash (.cle_in(cle), .ale_in(ale), .we_n_in(we_n),
		.re_n_in(re_n), .io_in(io_wire), .io_out(io_mod),
		.ready_busy_n_out(rb_n));

	// ==========================================================
	// bus tasks and checks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [12:0] a,
		input logic [2:0] sz, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {19'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= sz;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 99);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 99);
		rdata = hrdata;
		if (n >= 99) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	function automatic logic [15:0] fdat(input int k);
		return 16'h3c5a + 16'(k) * 16'h1111;
	endfunction

	initial begin
		logic [31:0] ex, msk;
		int n, sh, k0, i;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		bus(1'b0, nand_pkg::OFS_CONFIG, 3'h2, 0);
		chk("config", 32'h1000, rdata);
		bus(1'b1, nand_pkg::OFS_CONTROL, 3'h2, 0);
		bus(1'b1, nand_pkg::OFS_COMMAND, 3'h2, 32'h80);
		chk("command", 8'h80, i_flash.last_cmd);
		bus(1'b1, nand_pkg::OFS_ADDRESS, 3'h2, 32'h5a);
		chk("address", 8'h5a, i_flash.last_addr);
		bus(1'b1, nand_pkg::OFS_COMMAND, 3'h2, 32'h10);
		i = 0;
		do begin bus(1'b0, nand_pkg::OFS_STATUS, 3'h2, 0); i++; end
		while (rdata[0] !== 1'b1 && i < 200);
		chk("ready", 1'b1, rdata[0]);
		bus(1'b0, 12'h030, 3'h2, 0);
		chk("unmapped", 0, rdata);
		chk("select", {hresp, ce_n}, 2'b00);
		bus(1'b1, 13'h1004, 3'h2, 32'h5aa5c33c);
		bus(1'b0, 13'h1004, 3'h2, 0);
		chk("buffer", 32'h5aa5c33c, rdata);
		$display("test command and address done");
		for (int w = 0; w < 2; w++) begin
			bus(1'b1, nand_pkg::OFS_CONFIG, 3'h2, 32'h1000 | w);
			msk = w ? 32'hffff : 32'hff;
			for (int sz = w; sz < 3; sz++) for (int e = 0; e < 2; e++) begin
				n = (1 << sz) / (w + 1);
				bus(1'b1, nand_pkg::OFS_CONTROL, 3'h2, 32'(e) << 2);
				i_flash.wr_log.delete();
				bus(1'b1, nand_pkg::OFS_DATA, 3'(sz), 32'h8c6b4a29);
				chk("transfers", n, i_flash.wr_log.size());
				k0 = i_flash.rd_cnt;
				bus(1'b0, nand_pkg::OFS_DATA, 3'(sz), 0);
				ex = 0;
				for (int j = 0; j < n; j++) begin
					sh = (e ? n - 1 - j : j) * 8 * (w + 1);
					chk("write slot", (32'h8c6b4a29 >> sh) & msk,
						{16'h0, i_flash.wr_log[j]} & msk);
					ex |= ({16'h0, fdat(k0 + j)} & msk) << sh;
				end
				chk("read word", ex, rdata);
			end
		end
		$display("test data window done");
		bus(1'b1, nand_pkg::OFS_CONFIG, 3'h2, 32'h1000);
		bus(1'b1, nand_pkg::OFS_CONTROL, 3'h2, 32'h10);
		bus(1'b0, nand_pkg::OFS_MRES_LANE0, 3'h2, 0);
		chk("main cleared", 0, rdata);
		for (int pass = 0; pass < 2; pass++) begin
			bus(1'b1, nand_pkg::OFS_DATA, 3'h0, 32'h01);
			bus(1'b0, nand_pkg::OFS_MRES_LANE0, 3'h2, 0);
			chk("main parity", 32'h50555555, rdata);
			bus(1'b0, nand_pkg::OFS_SRES, 3'h2, 0);
			chk("spare parity", 32'h5455, rdata);
			bus(1'b1, nand_pkg::OFS_CONTROL, 3'h2, 32'h60);
		end
		k0 = i_flash.rd_cnt;
		bus(1'b0, nand_pkg::OFS_MECC_LOW, 3'h2, 0);
		chk("check read", {8'h0, 8'(fdat(k0 + 1)), 8'h0, 8'(fdat(k0))},
			rdata);
		$display("test parity done");
		tally_and_finish();
	end
endmodule // nand_sw_port_test
